// >>> verilog/cie_top.sv
// interrupt enable, status and apb register block of the clock chip
`timescale 1ns/1ns
module cie_top #(
   parameter int NUM_PINS = cie_pkg::CIE_NUM_GPIO
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic OTP_LOAD_FAIL,
   input wire logic NVM_LOAD_FAIL,
   input wire logic OTP_CRC_ERR,
   input wire logic NVM_CRC_ERR,
   input wire logic OTP_MANUAL_RDY,
   input wire logic [4:0] LOSS_LIMIT_EVT,
   input wire logic PLL_LOL_LIMIT_EVT,
   input wire logic [3:0] FREQ_EVT,
   input wire logic [4:0] SIGNAL_LOSS_EVT,
   input wire logic PLL_LOL_EVT,
   output logic DEVICE_IRQ,
   output logic [NUM_PINS-1:0] GPIO_IRQ,
   output logic BLOCK_IRQ
);
   import cie_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // status composition
   logic [31:0] enable_q;
   logic [31:0] status_raw;
   logic [31:0] event_q;
   logic [31:0] evmask_q;
   logic [2:0] pinsel_q;
   logic combined;
   logic device_irq_q;
   logic rd_status;

   // loader pair ORs, others mirror monitor events straight through
   always_comb begin
      status_raw = 32'h00000000;
      status_raw[CIE_FAIL_BIT] = OTP_LOAD_FAIL | NVM_LOAD_FAIL;
      status_raw[CIE_ERR_BIT] = OTP_CRC_ERR | NVM_CRC_ERR;
      status_raw[CIE_RDY_BIT] = OTP_MANUAL_RDY;
      status_raw[CIE_LMT_LO +: 5] = LOSS_LIMIT_EVT;
      status_raw[CIE_PLMT_BIT] = PLL_LOL_LIMIT_EVT;
      status_raw[CIE_FREQ_LO +: 4] = FREQ_EVT;
      status_raw[CIE_LOS_LO +: 5] = SIGNAL_LOSS_EVT;
      status_raw[CIE_PLOL_BIT] = PLL_LOL_EVT;
   end

   // enable mask selects sources; reserved enables are always zero
   assign combined = |(status_raw & enable_q & ~(32'h1 << CIE_GATE_BIT));

   ////////////////////////////////////////////////////////////////////
   // apb slave
   logic wr_en;
   logic rd_en;
   logic rd_load;
   logic rd_loaded_q;
   // zero wait states while running; a read whose setup edge fell while
   // frozen gets one wait state, else it would return stale data
   assign PREADY = CE && (PWRITE || rd_loaded_q);
   assign PSLVERR = 1'b0;
   assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
   assign rd_en = PSEL && PENABLE && !PWRITE && PREADY;
   // data fetched at the setup edge, or at the first running edge
   // of the access phase when the setup edge was frozen
   assign rd_load = PSEL && !PWRITE && CE && !rd_loaded_q;

   // read data loaded flag, dropped when the read completes
   always_ff @(posedge CLK) begin
      if (RST) begin
         rd_loaded_q <= 1'b0;
      end else if (CE) begin
         if (rd_load) begin
            rd_loaded_q <= 1'b1;
         end else if (rd_en) begin
            rd_loaded_q <= 1'b0;
         end
      end
   end

   // enable register; only documented bits can be written
   always_ff @(posedge CLK) begin
      if (RST) begin
         enable_q <= CIE_ENABLE_RST;
      end else if (wr_en && PADDR == CIE_ENABLE_OFF) begin
         enable_q <= PWDATA & CIE_ENABLE_WMASK;
      end
   end

   // gated device interrupt, registered so the pin is glitch free
   always_ff @(posedge CLK) begin
      if (RST) begin
         device_irq_q <= 1'b0;
      end else if (CE) begin
         device_irq_q <= combined && enable_q[CIE_GATE_BIT];
      end
   end
   assign DEVICE_IRQ = device_irq_q;

   // pin select register
   always_ff @(posedge CLK) begin
      if (RST) begin
         pinsel_q <= CIE_PINSEL_RST;
      end else if (wr_en && PADDR == CIE_PINSEL_OFF) begin
         pinsel_q <= PWDATA[2:0];
      end
   end

   // block event mask
   always_ff @(posedge CLK) begin
      if (RST) begin
         evmask_q <= CIE_EVENT_RST;
      end else if (wr_en && PADDR == CIE_EVMASK_OFF) begin
         evmask_q <= PWDATA & CIE_ENABLE_WMASK;
      end
   end

   // sticky event bits: read clears, but a new event wins over the clear
   assign rd_status = rd_en && PADDR == CIE_EVENT_OFF;
   always_ff @(posedge CLK) begin
      if (RST) begin
         event_q <= CIE_EVENT_RST;
      end else if (CE) begin
         event_q <= (rd_status ? 32'h00000000 : event_q) | status_raw;
      end
   end
   assign BLOCK_IRQ = |(event_q & evmask_q);

   // read data register
   always_ff @(posedge CLK) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
      end else if (rd_load) begin
         if (PADDR == CIE_ENABLE_OFF) begin
            PRDATA <= enable_q;
         end else if (PADDR == CIE_STATUS_OFF) begin
            PRDATA <= {combined, status_raw[30:0]};
         end else if (PADDR == CIE_EVENT_OFF) begin
            PRDATA <= event_q | status_raw;
         end else if (PADDR == CIE_EVMASK_OFF) begin
            PRDATA <= evmask_q;
         end else if (PADDR == CIE_PINSEL_OFF) begin
            PRDATA <= {29'h0, pinsel_q};
         end else begin
            PRDATA <= 32'h00000000; // unmapped reads zero
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin routing
   cie_pin_route #(.NUM_PINS(NUM_PINS)) u_route (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .irq_in(device_irq_q),
      .sel(pinsel_q),
      .pins_q(GPIO_IRQ)
   );

   ////////////////////////////////////////////////////////////////////
   // assertions
   property p_gate;
      @(posedge CLK) disable iff (RST)
         CE |=> (DEVICE_IRQ == ($past(combined) && $past(enable_q[31])));
   endproperty
   a_gate: assert property (p_gate) else $error("irq gate wrong");

   property p_fail;
      @(posedge CLK) disable iff (RST)
         (OTP_LOAD_FAIL || NVM_LOAD_FAIL) && enable_q[29] |-> combined;
   endproperty
   a_fail: assert property (p_fail) else $error("fail not seen");

   property p_err;
      @(posedge CLK) disable iff (RST)
         (OTP_CRC_ERR || NVM_CRC_ERR) && enable_q[28] |-> combined;
   endproperty
   a_err: assert property (p_err) else $error("err not seen");

   property p_rdy;
      @(posedge CLK) disable iff (RST)
         OTP_MANUAL_RDY && enable_q[27] |-> combined;
   endproperty
   a_rdy: assert property (p_rdy) else $error("rdy not seen");

   property p_lmt;
      @(posedge CLK) disable iff (RST)
         |(LOSS_LIMIT_EVT & enable_q[25:21]) |-> combined;
   endproperty
   a_lmt: assert property (p_lmt) else $error("limit not seen");

   property p_plmt;
      @(posedge CLK) disable iff (RST)
         PLL_LOL_LIMIT_EVT && enable_q[19] |-> combined;
   endproperty
   a_plmt: assert property (p_plmt) else $error("pll limit lost");

   property p_freq;
      @(posedge CLK) disable iff (RST)
         |(FREQ_EVT & enable_q[17:14]) |-> combined;
   endproperty
   a_freq: assert property (p_freq) else $error("freq not seen");

   property p_los;
      @(posedge CLK) disable iff (RST)
         |(SIGNAL_LOSS_EVT & enable_q[8:4]) |-> combined;
   endproperty
   a_los: assert property (p_los) else $error("loss not seen");

   property p_plol;
      @(posedge CLK) disable iff (RST)
         PLL_LOL_EVT && enable_q[0] |-> combined;
   endproperty
   a_plol: assert property (p_plol) else $error("pll lol lost");

   property p_rst;
      @(posedge CLK) RST |=> (enable_q == 32'h0 && !DEVICE_IRQ);
   endproperty
   a_rst: assert property (p_rst) else $error("reset not zero");

   property p_resv;
      @(posedge CLK) disable iff (RST)
         (enable_q & ~CIE_ENABLE_WMASK) == 32'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved set");

   property p_none;
      @(posedge CLK) disable iff (RST)
         (status_raw & enable_q & 32'h7FFFFFFF) == 32'h0 |-> !combined;
   endproperty
   a_none: assert property (p_none) else $error("spurious");

   sequence s_irq_up;
      CE && enable_q[31] && combined && pinsel_q == 3'h0
         ##1 CE && pinsel_q == 3'h0;
   endsequence
   property p_route;
      @(posedge CLK) disable iff (RST)
         s_irq_up |=> GPIO_IRQ[0];
   endproperty
   a_route: assert property (p_route) else $error("route lost");

   property p_one;
      @(posedge CLK) disable iff (RST)
         $onehot0(GPIO_IRQ);
   endproperty
   a_one: assert property (p_one) else $error("two pins");

   property p_rsto;
      @(posedge CLK)
         RST |=> PRDATA == 32'h0 && GPIO_IRQ == '0 && !BLOCK_IRQ;
   endproperty
   a_rsto: assert property (p_rsto) else $error("out not zero");

   ////////////////////////////////////////////////////////////////////
   // register bus assertions
   // a written enable word keeps only its documented bits
   property p_wrm;
      @(posedge CLK) disable iff (RST)
         wr_en && PADDR == CIE_ENABLE_OFF
            |=> enable_q == ($past(PWDATA) & CIE_ENABLE_WMASK);
   endproperty
   a_wrm: assert property (p_wrm) else $error("bad write");

   // status read: bit 31 is the masked or of the live sources
   property p_sts;
      @(posedge CLK) disable iff (RST)
         rd_load && PADDR == CIE_STATUS_OFF
            |=> PRDATA[31] == (|($past(status_raw) & $past(enable_q)
               & 32'h7FFFFFFF));
   endproperty
   a_sts: assert property (p_sts) else $error("sts read");

   property p_ldf;
      @(posedge CLK) disable iff (RST)
         rd_load && PADDR == CIE_STATUS_OFF
            |=> PRDATA[29] == ($past(OTP_LOAD_FAIL)
               || $past(NVM_LOAD_FAIL));
   endproperty
   a_ldf: assert property (p_ldf) else $error("fail read");

   // a frozen block keeps its enable, event, mask, pin select and irq regs
   property p_frz;
      @(posedge CLK) disable iff (RST)
         !CE |=> $stable(enable_q) && $stable(event_q)
            && $stable(evmask_q) && $stable(pinsel_q)
            && $stable(device_irq_q);
   endproperty
   a_frz: assert property (p_frz) else $error("not frozen");

   ////////////////////////////////////////////////////////////////////
   // sticky event assertions
   // a new event at a running edge is never lost, not even under a read clear
   property p_setw;
      @(posedge CLK) disable iff (RST)
         CE |=> (event_q & $past(status_raw)) == $past(status_raw);
   endproperty
   a_setw: assert property (p_setw) else $error("event lost");

   // read of the event word: setup, then access, then only new events
   sequence s_evt_rd;
      rd_load && PADDR == CIE_EVENT_OFF ##1 rd_status;
   endsequence
   property p_clr;
      @(posedge CLK) disable iff (RST)
         s_evt_rd |=> (event_q & ~$past(status_raw)) == 32'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("not cleared");

   // an unmasked event raises the block interrupt at the next edge
   property p_blk;
      @(posedge CLK) disable iff (RST)
         CE && |(status_raw & evmask_q)
            && !(wr_en && PADDR == CIE_EVMASK_OFF) |=> BLOCK_IRQ;
   endproperty
   a_blk: assert property (p_blk) else $error("no block irq");
endmodule

// >>> verilog/cie_pkg.sv
// constants and register map of the clock chip interrupt enable block
package cie_pkg;
   localparam logic [11:0] CIE_ENABLE_OFF = 12'h000;
   localparam logic [11:0] CIE_STATUS_OFF = 12'h004;
   localparam logic [11:0] CIE_EVENT_OFF = 12'h008;
   localparam logic [11:0] CIE_EVMASK_OFF = 12'h00C;
   localparam logic [11:0] CIE_PINSEL_OFF = 12'h010;
   localparam int CIE_GATE_BIT = 31;
   localparam int CIE_FAIL_BIT = 29;
   localparam int CIE_ERR_BIT = 28;
   localparam int CIE_RDY_BIT = 27;
   localparam int CIE_LMT_LO = 21;
   localparam int CIE_PLMT_BIT = 19;
   localparam int CIE_FREQ_LO = 14;
   localparam int CIE_LOS_LO = 4;
   localparam int CIE_PLOL_BIT = 0;
   localparam logic [31:0] CIE_ENABLE_WMASK = 32'hBBEBC1F1;
   localparam logic [31:0] CIE_ENABLE_RST = 32'h00000000;
   localparam logic [31:0] CIE_EVENT_RST = 32'h00000000;
   localparam logic [2:0] CIE_PINSEL_RST = 3'h0;
   localparam int CIE_NUM_GPIO = 4;
endpackage

// >>> verilog/cie_pin_route.sv
// routes the gated interrupt to one selected general-purpose pin
`timescale 1ns/1ns
module cie_pin_route #(
   parameter int NUM_PINS = 4
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic irq_in,
   input wire logic [2:0] sel,
   output logic [NUM_PINS-1:0] pins_q
);
   import cie_pkg::*;
   // pins come from flops so a select change never glitches a pin
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         always_ff @(posedge CLK) begin
            if (RST) begin
               pins_q[g] <= 1'b0;
            end else if (CE) begin
               pins_q[g] <= irq_in && (sel == 3'(g));
            end
         end
      end
   endgenerate
endmodule

// >>> tb/testbench.sv
// self-checking bench for the interrupt enable block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
   comparisons++; \
   if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
   end \
end
module testbench;
   import cie_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h00000000;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic DEVICE_IRQ;
   logic BLOCK_IRQ;
   logic [3:0] GPIO_IRQ;
   logic [20:0] ev = 21'h000000;
   logic [31:0] rd;
   logic [31:0] en;
   logic [31:0] s;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 4708;
   ////////////////////////////////////////////////////////////////////////
   // free-running 50 MHz clock
   always #10 CLK = ~CLK;
   cie_top i_dut (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .OTP_LOAD_FAIL(ev[20]), .NVM_LOAD_FAIL(ev[19]),
      .OTP_CRC_ERR(ev[18]), .NVM_CRC_ERR(ev[17]), .OTP_MANUAL_RDY(ev[16]),
      .LOSS_LIMIT_EVT(ev[15:11]), .PLL_LOL_LIMIT_EVT(ev[10]),
      .FREQ_EVT(ev[9:6]), .SIGNAL_LOSS_EVT(ev[5:1]), .PLL_LOL_EVT(ev[0]),
      .DEVICE_IRQ(DEVICE_IRQ), .GPIO_IRQ(GPIO_IRQ), .BLOCK_IRQ(BLOCK_IRQ));
   ////////////////////////////////////////////////////////////////////////
   // live status expected from the event levels and an enable word
   function automatic logic [31:0] exp_sts(input logic [31:0] e);
      logic [31:0] r;
      r = 32'h00000000;
      r[29] = ev[20] | ev[19];
      r[28] = ev[18] | ev[17];
      r[27] = ev[16];
      r[25:21] = ev[15:11];
      r[19] = ev[10];
      r[17:14] = ev[9:6];
      r[8:4] = ev[5:1];
      r[0] = ev[0];
      r[31] = |(r[30:0] & e[30:0] & CIE_ENABLE_WMASK[30:0]);
      return r;
   endfunction
   // one apb transfer; waits for pready, one idle edge after it
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      r = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // hang guard, well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge CLK);
      error_cnt++;
      summarize();
   end
   // main sequence: reset, bit walk, random mix, sticky events, pins
   initial begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      apb(1'b0, CIE_ENABLE_OFF, 32'h00000000, rd);
      `CHK("enable at reset", 32'h00000000, rd)
      `CHK("irq at reset", 1'b0, DEVICE_IRQ)
      apb(1'b1, CIE_ENABLE_OFF, 32'hFFFFFFFF, rd);
      apb(1'b0, CIE_ENABLE_OFF, 32'h00000000, rd);
      `CHK("enable writable bits", CIE_ENABLE_WMASK, rd)
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      apb(1'b0, CIE_ENABLE_OFF, 32'h00000000, rd);
      `CHK("enable after reset", 32'h00000000, rd)
      // every source active: only a mapped enable plus the gate fires
      ev <= 21'h1FFFFF;
      for (int b = 0; b < 32; b++) begin
         en = 32'h80000000 | (32'h00000001 << b);
         apb(1'b1, CIE_ENABLE_OFF, en, rd);
         repeat (2) @(posedge CLK);
         s = exp_sts(en);
         `CHK("irq per enable bit", s[31], DEVICE_IRQ)
      end
      // sparse random sources against random enables, gate included
      for (int i = 0; i < 60; i++) begin
         en = $random(seed) & $random(seed);
         apb(1'b1, CIE_ENABLE_OFF, en, rd);
         ev <= 21'($random(seed) & $random(seed) & $random(seed));
         repeat (2) @(posedge CLK);
         apb(1'b0, CIE_STATUS_OFF, 32'h00000000, rd);
         s = exp_sts(en);
         `CHK("status", s, rd)
         `CHK("device irq", en[31] & s[31], DEVICE_IRQ)
      end
      // sticky event: raised, masked, cleared by reading
      ev <= 21'h000000;
      apb(1'b1, CIE_ENABLE_OFF, 32'h00000001, rd);
      apb(1'b0, CIE_EVENT_OFF, 32'h00000000, rd);
      for (int m = 1; m >= 0; m--) begin
         apb(1'b1, CIE_EVMASK_OFF, 32'(m), rd);
         apb(1'b0, CIE_EVMASK_OFF, 32'h00000000, rd);
         `CHK("event mask", 32'(m), rd)
         ev <= 21'h000001;
         @(posedge CLK);
         ev <= 21'h000000;
         repeat (2) @(posedge CLK);
         `CHK("block irq", 1'(m), BLOCK_IRQ)
         apb(1'b0, CIE_EVENT_OFF, 32'h00000000, rd);
         `CHK("sticky event", 1'b1, rd[0])
         `CHK("block irq cleared", 1'b0, BLOCK_IRQ)
      end
      // route to each pin, then to selects with no pin behind them
      apb(1'b1, CIE_ENABLE_OFF, 32'h80000001, rd);
      ev <= 21'h000001;
      for (int p = 0; p < 6; p++) begin
         apb(1'b1, CIE_PINSEL_OFF, 32'(p), rd);
         repeat (3) @(posedge CLK);
         `CHK("pin route", 4'(p < 4 ? (1 << p) : 0), GPIO_IRQ)
      end
      apb(1'b1, 12'h100, 32'hDEADBEEF, rd);
      apb(1'b0, 12'h100, 32'h00000000, rd);
      `CHK("unmapped read", 32'h00000000, rd)
      `CHK("no slave error", 1'b0, PSLVERR)
      // frozen block: events wait, and a read stalls until it runs again
      ev <= 21'h000000;
      repeat (2) @(posedge CLK);
      CE <= 1'b0;
      ev <= 21'h000001;
      repeat (3) @(posedge CLK);
      `CHK("ready follows enable", 1'b0, PREADY)
      `CHK("frozen irq", 1'b0, DEVICE_IRQ)
      fork
         apb(1'b0, CIE_PINSEL_OFF, 32'h00000000, rd);
         begin
            repeat (3) @(posedge CLK);
            CE <= 1'b1;
         end
      join
      `CHK("pin select read", 32'h00000005, rd)
      `CHK("irq after freeze", 1'b1, DEVICE_IRQ)
      summarize();
   end
endmodule
